/* File: pkg/dbms_pkg.sv */
package dbms_pkg;

  // master reset hold time on sync out, in nanoseconds
  localparam int unsigned HOLD_NS     = 10000;
  localparam int unsigned CLK_NS      = 50;
  // least time rounds up to whole cycles
  localparam int unsigned HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;

  // request code field positions on bus a
  localparam int unsigned REQ_BIT     = 7;
  localparam int unsigned ADDR_LSB    = 4;
  localparam int unsigned KIND_BIT    = 3;
  // master reset parameter data-out positions
  localparam int unsigned MR_D2       = 7;
  localparam int unsigned MR_D1       = 4;
  localparam int unsigned MR_D0       = 1;
  // master reset data-out bits, usable positions only
  localparam logic [7:0]  MR_MASK     = 8'h92;
  // default master reset parameter: data out 2 and 1 set
  localparam logic [7:0]  MR_DEFAULT  = 8'h90;
  // reset value of bus a
  localparam logic [7:0]  BUS_RESET   = 8'h00;

  // sequence kinds a start pulse may ask for
  typedef enum logic [1:0] {
    DBMS_OP_MRST = 2'h0,
    DBMS_OP_XFER = 2'h1,
    DBMS_OP_INTR = 2'h2
  } dbms_op_t;

  // interface lines the sequencer drives
  typedef struct packed {
    logic       select_out;
    logic       master_out;
    logic       sync_out;
    logic [7:0] bus_a;
  } dbms_lines_t;

endpackage

/* File: design/dbms_seq.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// (RQ1) master reset: selout, masterout low, sync 10us
// (RQ2) then parameter on bus a, sync low
// (RQ3) parameter uses bits 7,4,1, exactly two set
// (RQ4) transfer settings: code to bus a, masterout
// (RQ5) settings code: 1, address 6:4, zeros
// (RQ6) drive returns settings byte, raises slave in
// (RQ7) acknowledged settings: drop master out
// (RQ8) drive drops slave in after master out
// (RQ9) command registers preloaded before interrupt request
// (RQ10) interrupt request: code to bus a, masterout
// (RQ11) interrupt code: 1, address, bit3 set
// (RQ12) drive answers with interrupt status byte
// (RQ13) acknowledged interrupt request: drop master out
// (RQ14) deselect must finish before new sequence
// (RQ15) wait slave in high, capture bus b
module dbms_seq #(
  parameter int unsigned HOLD_CYCLES = dbms_pkg::HOLD_CYC
) (
  // clock, enable, reset
  input  wire logic              i_mclk,
  input  wire logic              i_ce,
  input  wire logic              i_reset,
  // command side
  input  wire logic              i_start,      // one-cycle start pulse
  input  wire dbms_pkg::dbms_op_t i_op,        // sequence kind
  input  wire logic [7:0]        i_cmd_code,   // primary command register
  input  wire logic [7:0]        i_mr_param,   // master reset parameter
  input  wire logic              i_selected,   // drive still selected
  output logic                   o_busy,
  output logic                   o_done,       // one-cycle pulse
  output logic                   o_bad_cmd,    // last start was refused
  output logic [7:0]             o_resp,       // captured bus b byte
  // interface lines
  input  wire logic              i_slave_in,
  input  wire logic [7:0]        i_bus_b,
  output dbms_pkg::dbms_lines_t  o_lines
);

  // states one bit apart on each step away from idle
  typedef enum logic [2:0] {
    DBMS_IDLE  = 3'b000,
    DBMS_MAINT = 3'b001,
    DBMS_PARAM = 3'b011,
    DBMS_REQ   = 3'b010,
    DBMS_DESEL = 3'b110
  } dbms_state_t;

  dbms_state_t           state_q;
  dbms_pkg::dbms_lines_t lines_q;
  logic [13:0]           hold_q;      // maintenance hold counter
  logic                  done_q;
  logic                  bad_q;
  logic [7:0]            resp_q;
  logic                  is_intr_q;   // kind of pending request
  // parameter latched when it is checked, so a late change never
  // reaches bus a unchecked
  logic [7:0]            param_q;

  // true when exactly two data-out bits and no other bits are set in a master reset parameter
  function automatic logic mr_ok(input logic [7:0] p);
    logic [1:0] n;
    n = 2'(p[dbms_pkg::MR_D2]) + 2'(p[dbms_pkg::MR_D1])
      + 2'(p[dbms_pkg::MR_D0]);
    return (n == 2'h2) && ((p & ~dbms_pkg::MR_MASK) == 8'h00);
  endfunction

  // request code shape check, shared by both request kinds
  function automatic logic code_ok(input logic [7:0] c, input logic intr);
    return c[dbms_pkg::REQ_BIT] && (c[dbms_pkg::KIND_BIT] == intr)
      && (c[2:0] == 3'h0);
  endfunction

  logic start_ok;
  // a bad code is refused rather than put on the bus
  always_comb begin
    unique case (i_op)
      dbms_pkg::DBMS_OP_MRST: start_ok = mr_ok(i_mr_param);            // RQ3
      dbms_pkg::DBMS_OP_XFER: start_ok = code_ok(i_cmd_code, 1'b0);    // RQ5
      dbms_pkg::DBMS_OP_INTR: start_ok = code_ok(i_cmd_code, 1'b1);    // RQ11
      default:                start_ok = 1'b0;
    endcase
  end

  // new sequences only from idle with the drive deselected
  logic can_start;
  assign can_start = (state_q == DBMS_IDLE) && !i_selected            // RQ14
    && !i_slave_in;

  // main sequencer
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_q   <= DBMS_IDLE;
      lines_q   <= '0;
      hold_q    <= '0;
      is_intr_q <= 1'b0;
      param_q   <= 8'h00;
    end else if (i_ce) begin
      unique case (state_q)
        DBMS_IDLE: begin
          if (i_start && can_start && start_ok) begin
            if (i_op == dbms_pkg::DBMS_OP_MRST) begin
              // select and master out low, sync high
              lines_q.select_out <= 1'b0;                             // RQ1
              lines_q.master_out <= 1'b0;                             // RQ1
              lines_q.sync_out   <= 1'b1;                             // RQ1
              hold_q             <= '0;
              param_q            <= i_mr_param;                       // RQ3
              state_q            <= DBMS_MAINT;
            end else begin
              // primary command register straight onto bus a
              lines_q.bus_a      <= i_cmd_code;                       // RQ4
              lines_q.master_out <= 1'b1;                             // RQ10
              is_intr_q          <= (i_op == dbms_pkg::DBMS_OP_INTR);
              state_q            <= DBMS_REQ;
            end
          end
        end
        DBMS_MAINT: begin
          // hold sync for the full maintenance interval
          if (32'(hold_q) >= HOLD_CYCLES - 1) begin                   // RQ1
            lines_q.bus_a <= param_q;                                 // RQ2
            state_q       <= DBMS_PARAM;
          end else begin
            hold_q <= hold_q + 14'h1;
          end
        end
        DBMS_PARAM: begin
          // parameter already stable for a cycle before sync falls
          lines_q.sync_out <= 1'b0;                                   // RQ2
          state_q          <= DBMS_IDLE;
        end
        DBMS_REQ: begin
          // master out stays up until the drive answers
          if (i_slave_in) begin                                       // RQ15
            lines_q.master_out <= 1'b0;                               // RQ7 RQ13
            state_q            <= DBMS_DESEL;
          end
        end
        DBMS_DESEL: begin
          // drive drops slave in to return to idle
          if (!i_slave_in) begin                                      // RQ8
            lines_q.bus_a <= dbms_pkg::BUS_RESET;
            state_q       <= DBMS_IDLE;
          end
        end
        default: state_q <= DBMS_IDLE;
      endcase
    end
  end

  // response capture while slave in is high during the request
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      resp_q <= 8'h00;
    end else if (i_ce && state_q == DBMS_REQ && i_slave_in) begin
      resp_q <= i_bus_b;                                              // RQ15
    end
  end

  // completion pulse and refusal flag
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      done_q <= 1'b0;
      bad_q  <= 1'b0;
    end else if (i_ce) begin
      done_q <= ((state_q == DBMS_DESEL) && !i_slave_in)
             || (state_q == DBMS_PARAM);
      if (i_start && state_q == DBMS_IDLE) begin
        bad_q <= !(can_start && start_ok);
      end
    end
  end

  assign o_lines   = lines_q;
  assign o_busy    = (state_q != DBMS_IDLE);
  assign o_done    = done_q;
  assign o_bad_cmd = bad_q;
  assign o_resp    = resp_q;

  // ---- assertions ----
  property p_mr_hold;
    @(posedge i_mclk) disable iff (i_reset)
    ($rose(lines_q.sync_out)) |-> lines_q.sync_out[*8];
  endproperty
  a_mr_hold: assert property (p_mr_hold) else $error("sync out short"); // RQ1

  property p_mr_lines;
    @(posedge i_mclk) disable iff (i_reset)
    (state_q == DBMS_MAINT) |-> !lines_q.master_out && !lines_q.select_out;
  endproperty
  a_mr_lines: assert property (p_mr_lines) else $error("mr lines"); // RQ1

  property p_mr_param;
    @(posedge i_mclk) disable iff (i_reset)
    (state_q == DBMS_PARAM) |-> lines_q.sync_out && mr_ok(lines_q.bus_a);
  endproperty
  a_mr_param: assert property (p_mr_param) else $error("bad param"); // RQ3

  property p_req_code;
    @(posedge i_mclk) disable iff (i_reset)
    $rose(lines_q.master_out) |-> lines_q.bus_a[dbms_pkg::REQ_BIT]
      && (lines_q.bus_a[2:0] == 3'h0);
  endproperty
  a_req_code: assert property (p_req_code) else $error("bad code"); // RQ5

  property p_wait_ack;
    @(posedge i_mclk) disable iff (i_reset)
    ($fell(lines_q.master_out) && !$past(i_reset)) |-> $past(i_slave_in);
  endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("early drop"); // RQ15

  property p_drop;
    @(posedge i_mclk) disable iff (i_reset)
    (state_q == DBMS_REQ && i_slave_in && i_ce) |=> !lines_q.master_out;
  endproperty
  a_drop: assert property (p_drop) else $error("no drop"); // RQ7

  property p_resp;
    @(posedge i_mclk) disable iff (i_reset)
    (state_q == DBMS_REQ && i_slave_in && i_ce) |=>
      (o_resp == $past(i_bus_b));
  endproperty
  a_resp: assert property (p_resp) else $error("no capture"); // RQ15

  property p_idle_only;
    @(posedge i_mclk) disable iff (i_reset)
    (state_q == DBMS_IDLE && i_selected) |=> (state_q == DBMS_IDLE);
  endproperty
  a_idle_only: assert property (p_idle_only) else $error("busy start"); // RQ14

  c_mrst: cover property (@(posedge i_mclk) (state_q == DBMS_PARAM));
  c_req:  cover property (@(posedge i_mclk) $fell(lines_q.master_out));
  c_bad:  cover property (@(posedge i_mclk) $rose(bad_q));

endmodule // dbms_seq

`default_nettype wire

/* File: tb/dbms_drive.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural drive on the far side of the sequencer
module dbms_drive (
  // clock and request lines from the sequencer
  input  wire logic       i_mclk,
  input  wire logic       i_master_out,
  input  wire logic [7:0] i_bus_a,
  // interrupt status to report, answer lag in cycles
  input  wire logic [7:0] i_intr_stat,
  input  wire logic [3:0] i_lag,
  // answer lines
  output logic            o_slave_in = 1'b0,
  output logic [7:0]      o_bus_b    = 8'h00
);
  logic [3:0] cnt_q = 4'h0; // cycles since request seen
  // answer after the lag, let go once master out falls
  always_ff @(posedge i_mclk) begin
    if (i_master_out !== 1'b1) begin
      cnt_q      <= 4'h0;
      o_slave_in <= 1'b0;
      o_bus_b    <= ~o_bus_b; // released bus never holds a value
    end else if (cnt_q == i_lag) begin
      o_slave_in <= 1'b1;
      o_bus_b    <= i_bus_a[3] ? i_intr_stat : 8'h26;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // dbms_drive
`default_nettype wire

/* File: tb/dbms_seq_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dbms_seq_tb;
  localparam int unsigned HC = 10; // shortened hold for run time
  localparam dbms_pkg::dbms_op_t MR = dbms_pkg::DBMS_OP_MRST;
  localparam dbms_pkg::dbms_op_t XF = dbms_pkg::DBMS_OP_XFER;
  localparam dbms_pkg::dbms_op_t IR = dbms_pkg::DBMS_OP_INTR;
  // one case: inputs, then whether it must be refused
  typedef struct packed {
    dbms_pkg::dbms_op_t op;
    logic [7:0] code, par, st;
    logic [3:0] lag;
    logic       sel, bad;
  } dbms_row_t;
  localparam int NR = 11;
  localparam dbms_row_t ROWS [NR] = '{
    '{MR, 8'h00, 8'h90, 8'h00, 4'h0, 1'b0, 1'b0},
    '{MR, 8'h00, 8'h12, 8'h00, 4'h0, 1'b0, 1'b0},
    '{MR, 8'h00, 8'h82, 8'h00, 4'h0, 1'b0, 1'b0},
    '{MR, 8'h00, 8'h92, 8'h00, 4'h0, 1'b0, 1'b1},
    '{MR, 8'h00, 8'h91, 8'h00, 4'h0, 1'b0, 1'b1},
    '{XF, 8'h80, 8'h00, 8'h00, 4'h0, 1'b0, 1'b0},
    '{XF, 8'hf0, 8'h00, 8'h00, 4'h5, 1'b0, 1'b0},
    '{XF, 8'h81, 8'h00, 8'h00, 4'h0, 1'b0, 1'b1},
    '{XF, 8'h80, 8'h00, 8'h00, 4'h0, 1'b1, 1'b1},
    '{IR, 8'hd8, 8'h00, 8'h65, 4'h1, 1'b0, 1'b0},
    '{IR, 8'h90, 8'h00, 8'h4f, 4'h9, 1'b0, 1'b1}};
  logic i_mclk = 1'b0, i_reset = 1'b1, i_start = 1'b0, i_selected = 1'b0;
  logic ce = 1'b1; // clock enable, lowered by the freeze tests
  dbms_pkg::dbms_op_t i_op = MR;
  logic [7:0] i_cmd_code = 8'h00, i_mr_param = 8'h00, st = 8'h00;
  logic [3:0] lag = 4'h0;
  logic o_busy, o_done, o_bad_cmd, slave_in;
  logic [7:0] o_resp, bus_b;
  dbms_pkg::dbms_lines_t o_lines;
  int errors = 0, total_checks = 0, cyc = 0;
  dbms_seq #(.HOLD_CYCLES(HC)) dut (
    .i_mclk(i_mclk), .i_ce(ce), .i_reset(i_reset), .i_start(i_start),
    .i_op(i_op), .i_cmd_code(i_cmd_code), .i_mr_param(i_mr_param),
    .i_selected(i_selected), .o_busy(o_busy), .o_done(o_done),
    .o_bad_cmd(o_bad_cmd), .o_resp(o_resp), .i_slave_in(slave_in),
    .i_bus_b(bus_b), .o_lines(o_lines));
  dbms_drive drv (
    .i_mclk(i_mclk), .i_master_out(o_lines.master_out),
    .i_bus_a(o_lines.bus_a), .i_intr_stat(st), .i_lag(lag),
    .o_slave_in(slave_in), .o_bus_b(bus_b));
  initial forever #25 i_mclk = ~i_mclk;
  // hang guard, well above the longest case
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one sequence: start pulse, watch lines until done or refusal
  task automatic run(input dbms_row_t r);
    int n, ns;
    logic [7:0] ba, pa;
    logic sl, bz;
    n = 0; ns = 0; ba = 8'h00; pa = 8'h00; sl = 1'b0; bz = 1'b0;
    i_op = r.op; i_cmd_code = r.code; i_mr_param = r.par;
    st = r.st; lag = r.lag; i_selected = r.sel; i_start = 1'b1;
    @(posedge i_mclk); #1;
    i_start = 1'b0;
    do begin
      @(posedge i_mclk); #1;
      n++;
      ns += o_lines.sync_out;
      if (o_lines.master_out) ba = o_lines.bus_a;
      if (o_lines.sync_out) pa = o_lines.bus_a;
      sl |= o_lines.select_out;
      bz |= o_busy;
    end while (o_done !== 1'b1 && o_bad_cmd !== 1'b1 && n < 400);
    chk("bad", o_bad_cmd, r.bad);
    chk("done", o_done, !r.bad);
    chk("selout", sl, 1'b0);
    chk("busy", bz, !r.bad);
    if (!r.bad && r.op == MR) begin
      chk("hold", ns >= HC, 1'b1);
      chk("param", pa, r.par);
    end
    if (!r.bad && r.op != MR) begin
      chk("code", ba, r.code);
      chk("resp", o_resp, r.op == XF ? 8'h26 : r.st);
    end
    i_selected = 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge i_mclk);
    #1;
    chk("rst_bus_a", o_lines.bus_a, 8'h00);
    chk("rst_ctl", {5'h00, o_lines[10:8]}, 8'h00);
    chk("rst_busy", o_busy, 1'b0);
    i_reset = 1'b0;
    for (int i = 0; i < NR; i++) run(ROWS[i]);
    // reset in the middle of a hold drops sync out
    i_op = MR; i_mr_param = 8'h90; i_start = 1'b1;
    @(posedge i_mclk); #1;
    i_start = 1'b0;
    repeat (3) @(posedge i_mclk); #1;
    // frozen enable must stretch the hold, never end it
    ce = 1'b0;
    repeat (20) @(posedge i_mclk); #1;
    chk("ce_sync", o_lines.sync_out, 1'b1);
    chk("ce_busy", o_busy, 1'b1);
    ce = 1'b1;
    i_reset = 1'b1;
    @(posedge i_mclk); #1;
    i_reset = 1'b0;
    chk("mid_sync", o_lines.sync_out, 1'b0);
    chk("mid_busy", o_busy, 1'b0);
    run(ROWS[9]);
    // a start pulse while the enable is low must be lost
    ce = 1'b0; i_op = XF; i_cmd_code = 8'h80; i_start = 1'b1;
    @(posedge i_mclk); #1;
    i_start = 1'b0; ce = 1'b1;
    chk("ce_start", o_busy, 1'b0);
    chk("ce_mout", o_lines.master_out, 1'b0);
    final_report();
  end
endmodule // dbms_seq_tb
`default_nettype wire
